/* verilog/bridge_regs_pkg.sv */
// Package: offsets, field positions, reset values and timing for the bridge register bank
package bridge_regs_pkg;

  localparam logic [7:0] HOT_SWAP_OFFSET    = 8'h74;
  localparam logic [7:0] BRIDGE_CTRL_OFFSET = 8'h78;

  localparam logic [7:0] HS_CAP_ID_ON       = 8'h06;
  localparam logic [7:0] HS_CAP_ID_OFF      = 8'h00;
  localparam logic [7:0] HS_NEXT_PTR        = 8'h00;
  localparam logic [1:0] HS_PROG_IF         = 2'h1;

  localparam int HS_HIDE_ARM_BIT = 16;
  localparam int HS_ENUM_MASK_BIT = 17;
  localparam int HS_PENDING_BIT  = 18;
  localparam int HS_LED_BIT      = 19;
  localparam int HS_PROG_IF_LSB  = 20;
  localparam int HS_EXT_BIT      = 22;
  localparam int HS_INS_BIT      = 23;

  localparam int BC_SERR_FWD_BIT  = 2;
  localparam int BC_SEC_RESET_BIT = 3;
  localparam int BC_VGA_LSB       = 4;
  localparam int BC_VGA16_BIT     = 6;
  localparam int BC_MABORT_BIT    = 7;
  localparam int BC_PRI_TMO_BIT   = 8;
  localparam int BC_SEC_TMO_BIT   = 9;
  localparam int BC_TMO_STAT_BIT  = 10;
  localparam int BC_TMO_SERR_BIT  = 11;

  localparam int GPIO_OUT_CLR_LSB = 12;
  localparam int GPIO_OUT_SET_LSB = 16;
  localparam int GPIO_OE_CLR_LSB  = 20;
  localparam int GPIO_OE_SET_LSB  = 24;
  localparam int GPIO_IN_LSB      = 28;
  localparam int GPIO_WIDTH       = 4;

  localparam logic       INS_RESET     = 1'b1;
  localparam logic [1:0] VGA_IGNORE    = 2'h0;
  localparam logic [1:0] VGA_PRI_TO_SEC = 2'h1;
  localparam logic [1:0] VGA_SEC_TO_PRI = 2'h2;

  // Discard timer lengths as powers of two of PCI clocks
  localparam int TMO_LONG_LOG2  = 15;
  localparam int TMO_SHORT_LOG2 = 10;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  typedef struct packed {
    logic       serr_fwd_en;
    logic       sec_reset;
    logic [1:0] vga_mode;
    logic       vga_16bit;
    logic       mabort_report;
    logic       pri_short_tmo;
    logic       sec_short_tmo;
    logic       tmo_serr_en;
  } bridge_ctrl_type;

endpackage

/* verilog/bridge_hotswap_ctrl_gpio_regs.sv */
// Register bank: hot swap capability, bridge control and GPIO set/clear
module bridge_hotswap_ctrl_gpio_regs
#(
  parameter int GPIO_N = bridge_regs_pkg::GPIO_WIDTH
)
(
  input  wire logic              i_mclk,             // Bridge clock, 20 MHz
  input  wire logic              i_rst_n,            // Synchronous reset, active low
  input  wire logic [7:0]        i_addr,             // Register byte address
  input  wire logic [31:0]       i_wdata,            // Write data
  input  wire logic              i_wr,               // Write strobe
  input  wire logic              i_rd,               // Read strobe
  output logic      [31:0]       o_rdata,            // Read data, cycle after i_rd
  input  wire logic              i_hot_swap_strap_enable, // Hot swap strap
  input  wire logic              i_reverse_mode,     // 1 = reverse bridge
  input  wire logic              i_pcix_mode,        // 1 = secondary in PCI-X mode
  input  wire logic              i_ins_arm,          // Insertion armed by hot swap logic
  input  wire logic              i_ext_event,        // Extraction request pulse
  input  wire logic              i_pri_tmo_expire,   // Primary discard timer expired
  input  wire logic              i_sec_tmo_expire,   // Secondary discard timer expired
  input  wire logic              i_serr_event,       // System error seen
  input  wire logic [GPIO_N-1:0] i_gpio_in,          // GPIO input levels
  output logic                   o_enum_n,           // Enumeration output, active low
  output logic                   o_led,              // Hot swap LED, 1 = lit
  output logic                   o_hide_armed,       // Device hiding armed
  output logic                   o_sec_reset_n,      // Secondary bus reset, forward mode
  output logic                   o_hot_reset,        // Link hot reset, reverse mode
  output logic                   o_err_msg,          // Error message request pulse
  output logic                   o_serr_assert,      // System error assertion pulse
  output bridge_regs_pkg::bridge_ctrl_type o_ctrl,   // Forwarding and decode controls
  output logic                   o_pri_tmo_short,    // Primary timer 2^10 when 1
  output logic                   o_sec_tmo_short,    // Secondary timer 2^10 when 1
  output logic [GPIO_N-1:0]      o_gpio_out,         // GPIO output values
  output logic [GPIO_N-1:0]      o_gpio_oe           // GPIO output enables
);

  bridge_regs_pkg::reg_req_type req;
  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;
  assign req.wr    = i_wr;
  assign req.rd    = i_rd;

  wire logic wr_hs = req.wr && (req.addr == bridge_regs_pkg::HOT_SWAP_OFFSET);
  wire logic wr_bc = req.wr && (req.addr == bridge_regs_pkg::BRIDGE_CTRL_OFFSET);

  logic                         hide_arm_reg;
  logic                         enum_mask_reg;
  logic                         led_reg;
  logic                         ext_reg;
  logic                         ins_reg;
  logic                         tmo_stat_reg;
  bridge_regs_pkg::bridge_ctrl_type ctrl_reg;
  logic [GPIO_N-1:0]            gpio_out_reg;
  logic [GPIO_N-1:0]            gpio_oe_reg;
  logic [GPIO_N-1:0]            gpio_in_reg;
  logic                         pending;
  logic                         tmo_expire;

  assign tmo_expire = i_pri_tmo_expire || i_sec_tmo_expire;
  assign pending = i_ins_arm || ins_reg || ext_reg;

  // Hot swap control bits
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      hide_arm_reg  <= 1'b0;
      enum_mask_reg <= 1'b0;
      led_reg       <= 1'b0;
    end
    else if (wr_hs)
    begin
      hide_arm_reg  <= req.wdata[bridge_regs_pkg::HS_HIDE_ARM_BIT];
      enum_mask_reg <= req.wdata[bridge_regs_pkg::HS_ENUM_MASK_BIT];
      led_reg       <= req.wdata[bridge_regs_pkg::HS_LED_BIT];
    end
  end

  // Extraction and insertion flags; a new extraction event wins over a clear, insertion is only cleared
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      ext_reg <= 1'b0;
      ins_reg <= bridge_regs_pkg::INS_RESET;
    end
    else
    begin
      if (i_ext_event)
        ext_reg <= 1'b1;
      else if (wr_hs && req.wdata[bridge_regs_pkg::HS_EXT_BIT])
        ext_reg <= 1'b0;
      if (wr_hs && req.wdata[bridge_regs_pkg::HS_INS_BIT])
        ins_reg <= 1'b0;
    end
  end

  // Bridge control fields, with mode-dependent read-only bits
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      ctrl_reg <= '0;
    else if (wr_bc)
    begin
      if (!i_reverse_mode)
        ctrl_reg.serr_fwd_en <= req.wdata[bridge_regs_pkg::BC_SERR_FWD_BIT];
      ctrl_reg.sec_reset <= req.wdata[bridge_regs_pkg::BC_SEC_RESET_BIT];
      ctrl_reg.vga_mode  <= req.wdata[bridge_regs_pkg::BC_VGA_LSB +: 2];
      ctrl_reg.vga_16bit <= req.wdata[bridge_regs_pkg::BC_VGA16_BIT];
      ctrl_reg.mabort_report <= req.wdata[bridge_regs_pkg::BC_MABORT_BIT];
      if (i_reverse_mode)
        ctrl_reg.pri_short_tmo <= req.wdata[bridge_regs_pkg::BC_PRI_TMO_BIT];
      if (!i_reverse_mode)
        ctrl_reg.sec_short_tmo <= req.wdata[bridge_regs_pkg::BC_SEC_TMO_BIT];
      ctrl_reg.tmo_serr_en <= req.wdata[bridge_regs_pkg::BC_TMO_SERR_BIT];
    end
  end

  // Timeout status; expiry wins over a same-cycle clear
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      tmo_stat_reg <= 1'b0;
    else if (tmo_expire)
      tmo_stat_reg <= 1'b1;
    else if (wr_bc && req.wdata[bridge_regs_pkg::BC_TMO_STAT_BIT])
      tmo_stat_reg <= 1'b0;
  end

  // GPIO set/clear; set wins when both are written for one bit
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      gpio_out_reg <= '0;
      gpio_oe_reg  <= '0;
      gpio_in_reg  <= '0;
    end
    else
    begin
      gpio_in_reg <= i_gpio_in;
      if (wr_bc)
      begin
        gpio_out_reg <= (gpio_out_reg
                         & ~req.wdata[bridge_regs_pkg::GPIO_OUT_CLR_LSB +: GPIO_N])
                        | req.wdata[bridge_regs_pkg::GPIO_OUT_SET_LSB +: GPIO_N];
        gpio_oe_reg  <= (gpio_oe_reg
                         & ~req.wdata[bridge_regs_pkg::GPIO_OE_CLR_LSB +: GPIO_N])
                        | req.wdata[bridge_regs_pkg::GPIO_OE_SET_LSB +: GPIO_N];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_enum_n        <= 1'b1;
      o_led           <= 1'b0;
      o_hide_armed    <= 1'b0;
      o_sec_reset_n   <= 1'b1;
      o_hot_reset     <= 1'b0;
      o_err_msg       <= 1'b0;
      o_serr_assert   <= 1'b0;
      o_ctrl          <= '0;
      o_pri_tmo_short <= 1'b0;
      o_sec_tmo_short <= 1'b0;
      o_gpio_out      <= '0;
      o_gpio_oe       <= '0;
    end
    else
    begin
      o_enum_n <= !((ins_reg || ext_reg) && !enum_mask_reg);
      o_led <= led_reg;
      o_hide_armed <= hide_arm_reg;
      o_sec_reset_n <= !(ctrl_reg.sec_reset && !i_reverse_mode);
      o_hot_reset   <= ctrl_reg.sec_reset && i_reverse_mode;
      o_err_msg <= (!i_reverse_mode && ctrl_reg.serr_fwd_en && i_serr_event)
                   || (!i_reverse_mode && ctrl_reg.tmo_serr_en && !i_pcix_mode
                       && tmo_expire);
      o_serr_assert <= i_reverse_mode && ctrl_reg.tmo_serr_en && !i_pcix_mode
                       && tmo_expire;
      o_ctrl <= ctrl_reg;
      o_pri_tmo_short <= i_reverse_mode && ctrl_reg.pri_short_tmo;
      o_sec_tmo_short <= !i_reverse_mode && ctrl_reg.sec_short_tmo;
      o_gpio_out <= gpio_out_reg;
      o_gpio_oe  <= gpio_oe_reg;
    end
  end

  // Read data path; unmapped addresses read zero
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_rdata <= '0;
    else if (req.rd)
    begin
      case (req.addr)
        bridge_regs_pkg::HOT_SWAP_OFFSET:
        begin
          o_rdata <= '0;
          o_rdata[7:0] <= i_hot_swap_strap_enable ? bridge_regs_pkg::HS_CAP_ID_ON
                                                  : bridge_regs_pkg::HS_CAP_ID_OFF;
          o_rdata[15:8] <= bridge_regs_pkg::HS_NEXT_PTR;
          o_rdata[bridge_regs_pkg::HS_HIDE_ARM_BIT]  <= hide_arm_reg;
          o_rdata[bridge_regs_pkg::HS_ENUM_MASK_BIT] <= enum_mask_reg;
          o_rdata[bridge_regs_pkg::HS_PENDING_BIT]   <= pending;
          o_rdata[bridge_regs_pkg::HS_LED_BIT]       <= led_reg;
          o_rdata[bridge_regs_pkg::HS_PROG_IF_LSB +: 2] <= bridge_regs_pkg::HS_PROG_IF;
          o_rdata[bridge_regs_pkg::HS_EXT_BIT] <= ext_reg;
          o_rdata[bridge_regs_pkg::HS_INS_BIT] <= ins_reg;
        end
        bridge_regs_pkg::BRIDGE_CTRL_OFFSET:
        begin
          o_rdata <= '0;
          o_rdata[bridge_regs_pkg::BC_SERR_FWD_BIT]  <= ctrl_reg.serr_fwd_en;
          o_rdata[bridge_regs_pkg::BC_SEC_RESET_BIT] <= ctrl_reg.sec_reset;
          o_rdata[bridge_regs_pkg::BC_VGA_LSB +: 2]  <= ctrl_reg.vga_mode;
          o_rdata[bridge_regs_pkg::BC_VGA16_BIT]     <= ctrl_reg.vga_16bit;
          o_rdata[bridge_regs_pkg::BC_MABORT_BIT]    <= ctrl_reg.mabort_report;
          o_rdata[bridge_regs_pkg::BC_PRI_TMO_BIT]   <= ctrl_reg.pri_short_tmo;
          o_rdata[bridge_regs_pkg::BC_SEC_TMO_BIT]   <= ctrl_reg.sec_short_tmo;
          o_rdata[bridge_regs_pkg::BC_TMO_STAT_BIT]  <= tmo_stat_reg;
          o_rdata[bridge_regs_pkg::BC_TMO_SERR_BIT]  <= ctrl_reg.tmo_serr_en;
          o_rdata[bridge_regs_pkg::GPIO_IN_LSB +: GPIO_N] <= gpio_in_reg;
        end
        default:
          o_rdata <= '0;
      endcase
    end
    else
      o_rdata <= '0;
  end

endmodule

/* sim/bridge_regs_sva.sv */
// Port assertions for the bridge register bank
module bridge_regs_sva
#(
  parameter int GPIO_N = 4
)
(
  input wire logic              i_mclk,           // Clock
  input wire logic              i_rst_n,          // Reset
  input wire logic [7:0]        i_addr,           // Address
  input wire logic [31:0]       i_wdata,          // Write data
  input wire logic              i_wr,             // Write
  input wire logic              i_rd,             // Read
  input wire logic [31:0]       o_rdata,          // Read data
  input wire logic              i_hot_swap_strap_enable, // Strap
  input wire logic              i_reverse_mode,   // Reverse
  input wire logic              i_pcix_mode,      // PCI-X
  input wire logic              i_pri_tmo_expire, // Timer
  input wire logic              i_sec_tmo_expire, // Timer
  input wire logic              i_serr_event,     // Error
  input wire logic              o_led,            // LED
  input wire logic              o_sec_reset_n,    // Bus reset
  input wire logic              o_hot_reset,      // Hot reset
  input wire logic              o_err_msg,        // Message
  input wire logic              o_serr_assert,    // Assertion
  input wire bridge_regs_pkg::bridge_ctrl_type o_ctrl, // Controls
  input wire logic [GPIO_N-1:0] o_gpio_out        // GPIO out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SET = bridge_regs_pkg::GPIO_OUT_SET_LSB;
  localparam int CLR = bridge_regs_pkg::GPIO_OUT_CLR_LSB;
  logic fwd_cause;
  logic rev_cause;
  // Timer errors are meaningless in PCI-X mode, so only system errors count there
  assign fwd_cause = !i_reverse_mode && (i_serr_event ||
                     (!i_pcix_mode && (i_pri_tmo_expire || i_sec_tmo_expire)));
  assign rev_cause = i_reverse_mode && !i_pcix_mode && (i_pri_tmo_expire || i_sec_tmo_expire);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence hs_wr;
    i_wr && i_addr == bridge_regs_pkg::HOT_SWAP_OFFSET;
  endsequence
  sequence hs_rd;
    i_rd && i_addr == bridge_regs_pkg::HOT_SWAP_OFFSET;
  endsequence
  sequence bc_wr;
    i_wr && i_addr == bridge_regs_pkg::BRIDGE_CTRL_OFFSET;
  endsequence
  cap_id_read_a: assert property (hs_rd |=>
    o_rdata[7:0] == ($past(i_hot_swap_strap_enable) ? 8'h06 : 8'h00)) else $error("cap id");
  next_ptr_read_a: assert property (hs_rd |=> o_rdata[15:8] == 8'h00)
    else $error("next pointer");
  prog_if_read_a: assert property (hs_rd |=> o_rdata[21:20] == 2'h1)
    else $error("prog interface");
  led_write_a: assert property (hs_wr |-> ##2 o_led == $past(i_wdata[19], 2))
    else $error("led");
  gpio_set_clr_a: assert property (bc_wr |-> ##2
    ((o_gpio_out & $past(i_wdata[SET +: GPIO_N], 2)) == $past(i_wdata[SET +: GPIO_N], 2)) &&
    ((o_gpio_out & $past(i_wdata[CLR +: GPIO_N], 2) & ~$past(i_wdata[SET +: GPIO_N], 2)) == '0))
    else $error("gpio out");
  sec_reset_fwd_a: assert property
    (o_sec_reset_n == !(o_ctrl.sec_reset && !$past(i_reverse_mode))) else $error("sec reset");
  hot_reset_rev_a: assert property
    (o_hot_reset == (o_ctrl.sec_reset && $past(i_reverse_mode))) else $error("hot reset");
  err_msg_cause_a: assert property (o_err_msg |-> $past(fwd_cause))
    else $error("err msg");
  serr_cause_a: assert property ($rose(o_serr_assert) |-> $past(rev_cause))
    else $error("serr");
endmodule

bind bridge_hotswap_ctrl_gpio_regs bridge_regs_sva #(.GPIO_N(GPIO_N)) i_bridge_regs_sva (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_hot_swap_strap_enable(i_hot_swap_strap_enable),
  .i_reverse_mode(i_reverse_mode), .i_pcix_mode(i_pcix_mode),
  .i_pri_tmo_expire(i_pri_tmo_expire), .i_sec_tmo_expire(i_sec_tmo_expire),
  .i_serr_event(i_serr_event), .o_led(o_led), .o_sec_reset_n(o_sec_reset_n),
  .o_hot_reset(o_hot_reset), .o_err_msg(o_err_msg), .o_serr_assert(o_serr_assert),
  .o_ctrl(o_ctrl), .o_gpio_out(o_gpio_out));

/* sim/bridge_hotswap_ctrl_gpio_regs_tb.sv */
// Self-checking bench for the bridge register bank
module bridge_hotswap_ctrl_gpio_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
  } row_type;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        strap = 1'b1, rev = 1'b0, pcix = 1'b0, arm = 1'b0;
  logic [3:0]  ev = 4'h0, gin = 4'hA;
  logic [31:0] o_rdata;
  logic        enum_n, sec_rst_n, hot_rst, err_msg, serr, pri_short, sec_short, hide, led;
  bridge_regs_pkg::bridge_ctrl_type ctrl;
  logic [3:0]  gout, goe;
  int          miscompares = 0, samples_checked = 0;
  // Reads carry the expected data, writes the data written
  row_type rows [10] = '{
    '{1'b0, 8'h74, 32'h0094_0006}, '{1'b1, 8'h74, 32'h000B_0000},
    '{1'b0, 8'h74, 32'h009F_0006}, '{1'b1, 8'h74, 32'h0080_0000},
    '{1'b0, 8'h74, 32'h0010_0006}, '{1'b1, 8'h78, 32'h0F0F_0FFC},
    '{1'b0, 8'h78, 32'hA000_0AFC}, '{1'b0, 8'h7C, 32'h0000_0000},
    '{1'b1, 8'h78, 32'h00F1_5000}, '{1'b0, 8'h78, 32'hA000_0000}};
  always #25 i_mclk = ~i_mclk;
  bridge_hotswap_ctrl_gpio_regs i_bridge_hotswap_ctrl_gpio_regs (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_hot_swap_strap_enable(strap), .i_reverse_mode(rev),
    .i_pcix_mode(pcix), .i_ins_arm(arm), .i_ext_event(ev[0]), .i_pri_tmo_expire(ev[1]),
    .i_sec_tmo_expire(ev[2]), .i_serr_event(ev[3]), .i_gpio_in(gin), .o_enum_n(enum_n),
    .o_led(led), .o_hide_armed(hide), .o_sec_reset_n(sec_rst_n), .o_hot_reset(hot_rst),
    .o_err_msg(err_msg), .o_serr_assert(serr), .o_ctrl(ctrl), .o_pri_tmo_short(pri_short),
    .o_sec_tmo_short(sec_short), .o_gpio_out(gout), .o_gpio_oe(goe));
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK("rdata", e, o_rdata)
  endtask
  // Outputs lag a write by two edges
  task automatic settle;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  // Bit 0 extraction, 1 primary timer, 2 secondary timer, 3 system error
  task automatic pulse(input logic [3:0] p);
    @(posedge i_mclk);
    ev <= p;
    @(posedge i_mclk);
    ev <= 4'h0;
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    settle();
    `CHK("enum_n", 1'b0, enum_n)
    `CHK("sec_rst_n", 1'b1, sec_rst_n)
    foreach (rows[k])
      if (rows[k].wr)
        wr_reg(rows[k].addr, rows[k].data);
      else
        rd_reg(rows[k].addr, rows[k].data);
    settle();
    `CHK("gpio_out", 4'hB, gout)
    `CHK("gpio_oe", 4'h0, goe)
    `CHK("enum_n", 1'b1, enum_n)
    pulse(4'h1);
    settle();
    `CHK("enum_n", 1'b0, enum_n)
    wr_reg(8'h74, 32'h0002_0000);
    settle();
    `CHK("enum_n", 1'b1, enum_n)
    rd_reg(8'h74, 32'h0056_0006);
    wr_reg(8'h74, 32'h0040_0000);
    rd_reg(8'h74, 32'h0010_0006);
    wr_reg(8'h74, 32'h0009_0000);
    settle();
    `CHK("hide", 1'b1, hide)
    `CHK("led", 1'b1, led)
    arm <= 1'b1;
    rd_reg(8'h74, 32'h001D_0006);
    arm <= 1'b0;
    wr_reg(8'h78, 32'h0000_0808);
    settle();
    `CHK("sec_rst_n", 1'b0, sec_rst_n)
    rev <= 1'b1;
    settle();
    `CHK("hot_rst", 1'b1, hot_rst)
    wr_reg(8'h78, 32'h0000_0B04);
    rd_reg(8'h78, 32'hA000_0900);
    settle();
    `CHK("pri_short", 1'b1, pri_short)
    `CHK("sec_short", 1'b0, sec_short)
    pulse(4'h4);
    `CHK("serr", 1'b1, serr)
    `CHK("err_msg", 1'b0, err_msg)
    rd_reg(8'h78, 32'hA000_0D00);
    wr_reg(8'h78, 32'h0000_0D00);
    rd_reg(8'h78, 32'hA000_0900);
    rev <= 1'b0;
    wr_reg(8'h78, 32'h0000_0804);
    rd_reg(8'h78, 32'hA000_0904);
    `CHK("ctrl", 9'h105, ctrl)
    pulse(4'h8);
    `CHK("err_msg", 1'b1, err_msg)
    pcix <= 1'b1;
    pulse(4'h2);
    `CHK("err_msg", 1'b0, err_msg)
    pcix <= 1'b0;
    strap <= 1'b0;
    rd_reg(8'h74, 32'h0019_0000);
    strap <= 1'b1;
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd_reg(8'h74, 32'h0094_0006);
    rd_reg(8'h78, 32'hA000_0000);
    `CHK("gpio_out", 4'h0, gout)
    end_sim();
  end
endmodule
